// ### ilrs_pkg.sv
// constants and register map of the interlock and relay sequencer
//======================================================================
package ilrs_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_SEQ_DLY = 8'h04;
  localparam logic [7:0] OFS_FLT_TMO = 8'h08;
  localparam logic [7:0] OFS_PULL_PCT = 8'h0c;
  localparam logic [7:0] OFS_HOLD_PCT = 8'h10;
  localparam logic [7:0] OFS_OPEN_DLY = 8'h14;
  localparam logic [7:0] OFS_TRAC_MAX = 8'h18;
  localparam logic [7:0] OFS_ILK_PCT = 8'h1c;
  localparam logic [7:0] OFS_STATUS = 8'h20;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h24;
  localparam logic [7:0] OFS_IRQ_CLR = 8'h28;
  localparam logic [7:0] OFS_IRQ_EN = 8'h2c;
  // control register bit positions
  localparam int CTRL_ILK_SRC = 0;
  localparam int CTRL_FLT_ROUTE = 1;
  localparam int CTRL_MAIN_ILK = 2;
  localparam int CTRL_ANG_ILK = 3;
  // interrupt event bit positions
  localparam int EV_ILK_OFF = 0;
  localparam int EV_RELAY_ON = 1;
  localparam int EV_FLT_OFF = 2;
  localparam int EV_COMM_LOST = 3;
  // values after reset
  localparam logic [3:0] CTRL_RST = 4'h8;
  localparam logic [5:0] SEQ_DLY_RST = 6'h00;
  localparam logic [6:0] FLT_TMO_RST = 7'h00;
  localparam logic [6:0] PULL_PCT_RST = 7'h64;
  localparam logic [6:0] HOLD_PCT_RST = 7'h64;
  localparam logic [8:0] OPEN_DLY_RST = 9'h000;
  localparam logic [12:0] TRAC_MAX_RST = 13'h0000;
  localparam logic [6:0] ILK_PCT_RST = 7'h00;
  // timing
  localparam int CLK_NS = 50;
  localparam int TICK_MS = 100;
  localparam int TICK_CYCLES_DFLT = TICK_MS * 1000000 / CLK_NS;
  localparam int PULLIN_MS = 1000;
  localparam logic [8:0] PULLIN_TICKS = 9'(PULLIN_MS / TICK_MS);
  localparam logic [6:0] PWM_STEPS = 7'h64;
  // fault and angle output
  localparam logic [5:0] COMM_LOST_CODE = 6'h3f;
  localparam logic [6:0] ANGLE_MAX_DEG = 7'h5a;
  localparam logic [13:0] ANGLE_BASE_MV = 14'h1388;
  localparam logic [13:0] ANGLE_LOCK_MV = 14'h2710;
  // 4000 mV over 90 deg, scaled by 256
  localparam logic [20:0] ANGLE_GAIN = 21'h2c72;
endpackage

// ### ilrs_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
`default_nettype none
module ilrs_sync #(
  parameter int W = 2
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  import ilrs_pkg::*;
  logic [W-1:0] meta_r;
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      always_ff @(posedge ref_clk or negedge rst_b)
      begin
        if (!rst_b)
        begin
          meta_r[i] <= 1'b0;
          q[i] <= 1'b0;
        end
        else
        begin
          meta_r[i] <= d[i];
          q[i] <= meta_r[i];
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ### ilrs_delay.sv
// tick-based delay counter, reloaded on start
`timescale 1ns/10ps
`default_nettype none
module ilrs_delay (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic start,
  input wire logic tick,
  input wire logic [8:0] len,
  output logic busy
);
  import ilrs_pkg::*;
  logic [8:0] cnt_r;
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      cnt_r <= 9'h000;
    else if (start)
      cnt_r <= len;
    else if (tick && cnt_r != 9'h000)
      cnt_r <= cnt_r - 9'h001;
  end
  assign busy = (cnt_r != 9'h000);
endmodule
`default_nettype wire

// ### ilrs_top.sv
// interlock, relay and fault output sequencer of the steering controller
//
// Our own choices: the address-and-strobe port and the address map.
`timescale 1ns/10ps
`default_nettype none
module ilrs_top #(
  parameter int unsigned TICK_CYCLES = ilrs_pkg::TICK_CYCLES_DFLT
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic key_switch_input,
  input wire logic ilk_switch,
  input wire logic [12:0] trac_speed_rpm,
  input wire logic fault_action,
  input wire logic prog_attached,
  input wire logic comm_lost_in,
  input wire logic [6:0] wheel_angle_deg,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  output logic relay_pwm,
  output logic relay_on,
  output logic fault_to_ilk,
  output logic fault_to_coil,
  output logic [5:0] fault_code,
  output logic [13:0] angle_out_mv,
  output logic irq
);
  import ilrs_pkg::*;

  //======================================================================
  // state
  typedef struct packed {
    logic [20:0] tick_cnt;
    logic tick;
    logic ilk_q;
    logic ilk_act;
    logic dem_q;
    logic relay_on;
    logic flt_q;
    logic flt_out;
    logic comm_q;
    logic [6:0] pwm_cnt;
    logic relay_pwm;
    logic [3:0] ctrl;
    logic [5:0] seq_dly;
    logic [6:0] flt_tmo;
    logic [6:0] pull_pct;
    logic [6:0] hold_pct;
    logic [8:0] open_dly;
    logic [12:0] trac_max;
    logic [6:0] ilk_pct;
    logic [3:0] irq_stat;
    logic [3:0] irq_en;
    logic [31:0] rdata;
    logic [13:0] angle_mv;
    logic [5:0] fault_code;
  } ilrs_state_type;

  ilrs_state_type s_r;
  ilrs_state_type s_nxt;

  function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] ofs, input logic w);
    wr_hit = w && (a == ofs);
  endfunction

  //======================================================================
  // pins and timers
  logic key_s;
  logic ilk_sw_s;
  logic seq_busy;
  logic open_busy;
  logic pull_busy;
  logic flt_busy;
  logic seq_start;
  logic open_start;
  logic pull_start;
  logic flt_start;

  ilrs_sync #(.W(2)) u_sync (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .d({key_switch_input, ilk_switch}),
    .q({key_s, ilk_sw_s})
  );

  ilrs_delay u_seq (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .start(seq_start),
    .tick(s_r.tick),
    .len({3'h0, s_r.seq_dly}),
    .busy(seq_busy)
  );

  ilrs_delay u_open (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .start(open_start),
    .tick(s_r.tick),
    .len(s_r.open_dly),
    .busy(open_busy)
  );

  ilrs_delay u_pull (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .start(pull_start),
    .tick(s_r.tick),
    .len(PULLIN_TICKS),
    .busy(pull_busy)
  );

  ilrs_delay u_flt (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .start(flt_start),
    .tick(s_r.tick),
    .len({2'h0, s_r.flt_tmo}),
    .busy(flt_busy)
  );

  //======================================================================
  // next state
  logic ilk_raw;
  logic auto_en;
  logic ilk_in;
  logic demand;
  logic comm_lost;
  logic [6:0] level;
  logic [19:0] speed_scaled;
  logic [19:0] limit_scaled;
  logic [6:0] angle_clip;
  logic [20:0] angle_prod;
  logic [3:0] ev;

  always_comb
  begin
    s_nxt = s_r;
    // common timebase
    if (s_r.tick_cnt >= 21'(TICK_CYCLES - 1))
    begin
      s_nxt.tick_cnt = 21'h000000;
      s_nxt.tick = 1'b1;
    end
    else
    begin
      s_nxt.tick_cnt = s_r.tick_cnt + 21'h000001;
      s_nxt.tick = 1'b0;
    end

    ilk_raw = s_r.ctrl[CTRL_ILK_SRC] ? ilk_sw_s : key_s;
    speed_scaled = 20'(trac_speed_rpm) * 20'd100;
    limit_scaled = 20'(s_r.ilk_pct) * 20'(s_r.trac_max);
    auto_en = (s_r.ilk_pct != 7'h00) && (speed_scaled > limit_scaled);
    ilk_in = ilk_raw | auto_en;
    s_nxt.ilk_q = ilk_in;
    seq_start = s_r.ilk_q & ~ilk_in;
    s_nxt.ilk_act = ilk_in | (s_r.ilk_act & (s_r.ilk_q | seq_busy));

    demand = s_r.ctrl[CTRL_MAIN_ILK] ? s_r.ilk_act : key_s;
    s_nxt.dem_q = demand;
    open_start = s_r.dem_q & ~demand;
    s_nxt.relay_on = demand | (s_r.relay_on & (s_r.dem_q | open_busy));
    pull_start = s_nxt.relay_on & ~s_r.relay_on;
    level = (pull_busy | pull_start) ? s_r.pull_pct : s_r.hold_pct;
    if (s_r.pwm_cnt >= PWM_STEPS - 7'h01)
      s_nxt.pwm_cnt = 7'h00;
    else
      s_nxt.pwm_cnt = s_r.pwm_cnt + 7'h01;
    s_nxt.relay_pwm = s_r.relay_on && (s_r.pwm_cnt < level);

    flt_start = fault_action & ~s_r.flt_q;
    s_nxt.flt_q = fault_action;
    s_nxt.flt_out = ~(fault_action & ~flt_start & ~flt_busy);

    comm_lost = prog_attached & comm_lost_in;
    s_nxt.comm_q = comm_lost;
    s_nxt.fault_code = comm_lost ? COMM_LOST_CODE : 6'h00;
    angle_clip = (wheel_angle_deg > ANGLE_MAX_DEG) ? ANGLE_MAX_DEG : wheel_angle_deg;
    angle_prod = 21'(angle_clip) * ANGLE_GAIN;
    if (s_r.ctrl[CTRL_ANG_ILK] && comm_lost)
      s_nxt.angle_mv = ANGLE_LOCK_MV;
    else
      s_nxt.angle_mv = ANGLE_BASE_MV + 14'(angle_prod >> 8);

    // interrupt events
    ev = 4'h0;
    ev[EV_ILK_OFF] = s_r.ilk_act & ~s_nxt.ilk_act;
    ev[EV_RELAY_ON] = pull_start;
    ev[EV_FLT_OFF] = s_r.flt_out & ~s_nxt.flt_out;
    ev[EV_COMM_LOST] = comm_lost & ~s_r.comm_q;
    // set wins over clear
    if (wr_hit(addr, OFS_IRQ_CLR, wr))
      s_nxt.irq_stat = (s_r.irq_stat & ~wdata[3:0]) | ev;
    else
      s_nxt.irq_stat = s_r.irq_stat | ev;

    // register writes
    if (wr_hit(addr, OFS_CTRL, wr))
      s_nxt.ctrl = wdata[3:0];
    if (wr_hit(addr, OFS_SEQ_DLY, wr))
      s_nxt.seq_dly = wdata[5:0];
    if (wr_hit(addr, OFS_FLT_TMO, wr))
      s_nxt.flt_tmo = wdata[6:0];
    if (wr_hit(addr, OFS_PULL_PCT, wr))
      s_nxt.pull_pct = wdata[6:0];
    if (wr_hit(addr, OFS_HOLD_PCT, wr))
      s_nxt.hold_pct = wdata[6:0];
    if (wr_hit(addr, OFS_OPEN_DLY, wr))
      s_nxt.open_dly = wdata[8:0];
    if (wr_hit(addr, OFS_TRAC_MAX, wr))
      s_nxt.trac_max = wdata[12:0];
    if (wr_hit(addr, OFS_ILK_PCT, wr))
      s_nxt.ilk_pct = wdata[6:0];
    if (wr_hit(addr, OFS_IRQ_EN, wr))
      s_nxt.irq_en = wdata[3:0];

    // register reads, answer in the next cycle only
    s_nxt.rdata = 32'h00000000;
    if (rd)
    begin
      case (addr)
        OFS_CTRL: s_nxt.rdata = {28'h0, s_r.ctrl};
        OFS_SEQ_DLY: s_nxt.rdata = {26'h0, s_r.seq_dly};
        OFS_FLT_TMO: s_nxt.rdata = {25'h0, s_r.flt_tmo};
        OFS_PULL_PCT: s_nxt.rdata = {25'h0, s_r.pull_pct};
        OFS_HOLD_PCT: s_nxt.rdata = {25'h0, s_r.hold_pct};
        OFS_OPEN_DLY: s_nxt.rdata = {23'h0, s_r.open_dly};
        OFS_TRAC_MAX: s_nxt.rdata = {19'h0, s_r.trac_max};
        OFS_ILK_PCT: s_nxt.rdata = {25'h0, s_r.ilk_pct};
        OFS_STATUS: s_nxt.rdata = {26'h0, s_r.comm_q, s_r.flt_out, pull_busy, s_r.relay_on, auto_en, s_r.ilk_act};
        OFS_IRQ_STAT: s_nxt.rdata = {28'h0, s_r.irq_stat};
        OFS_IRQ_EN: s_nxt.rdata = {28'h0, s_r.irq_en};
        default: s_nxt.rdata = 32'h00000000;
      endcase
    end
  end

  //======================================================================
  // registers
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s_r <= '0;
      s_r.ctrl <= CTRL_RST;
      s_r.seq_dly <= SEQ_DLY_RST;
      s_r.flt_tmo <= FLT_TMO_RST;
      s_r.pull_pct <= PULL_PCT_RST;
      s_r.hold_pct <= HOLD_PCT_RST;
      s_r.open_dly <= OPEN_DLY_RST;
      s_r.trac_max <= TRAC_MAX_RST;
      s_r.ilk_pct <= ILK_PCT_RST;
      s_r.angle_mv <= ANGLE_BASE_MV;
    end
    else
      s_r <= s_nxt;
  end

  //======================================================================
  // outputs
  assign rdata = s_r.rdata;
  assign relay_pwm = s_r.relay_pwm;
  assign relay_on = s_r.relay_on;
  assign fault_to_ilk = s_r.flt_out & ~s_r.ctrl[CTRL_FLT_ROUTE];
  assign fault_to_coil = s_r.flt_out & s_r.ctrl[CTRL_FLT_ROUTE];
  assign fault_code = s_r.fault_code;
  assign angle_out_mv = s_r.angle_mv;
  assign irq = |(s_r.irq_stat & s_r.irq_en);
endmodule
`default_nettype wire

// ### ilrs_trac_model.sv
// traction controller model at the far side of the sequencer
`timescale 1ns/10ps
`default_nettype none
module ilrs_trac_model #(
  parameter logic [13:0] LIMIT_MV = 14'h2328
) (
  input wire logic ref_clk,
  input wire logic [12:0] speed_cmd,
  input wire logic [13:0] angle_out_mv,
  output logic [12:0] trac_speed_rpm
);
  always_ff @(posedge ref_clk)
  begin
    trac_speed_rpm <= (angle_out_mv > LIMIT_MV) ? speed_cmd >> 1 : speed_cmd;
  end
endmodule
`default_nettype wire

// ### ilrs_properties.sv
// port checker of the sequencer
`timescale 1ns/10ps
`default_nettype none
module ilrs_properties (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic prog_attached,
  input wire logic comm_lost_in,
  input wire logic fault_action,
  input wire logic [6:0] wheel_angle_deg,
  input wire logic relay_pwm,
  input wire logic relay_on,
  input wire logic fault_to_ilk,
  input wire logic fault_to_coil,
  input wire logic [5:0] fault_code,
  input wire logic [13:0] angle_out_mv
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  //======================================================================
  // properties
  property p_code_set;
    prog_attached && comm_lost_in |=> fault_code == 6'h3f;
  endproperty
  a_code_set: assert property (p_code_set) else $error("fault code not 63");
  property p_code_clr;
    !(prog_attached && comm_lost_in) |=> fault_code == 6'h00;
  endproperty
  a_code_clr: assert property (p_code_clr) else $error("fault code stuck");
  property p_route;
    !(fault_to_ilk && fault_to_coil);
  endproperty
  a_route: assert property (p_route) else $error("fault on both routes");
  property p_pwm_on;
    relay_pwm |-> relay_on || $past(relay_on);
  endproperty
  a_pwm_on: assert property (p_pwm_on) else $error("coil driven while open");
  property p_pwm_off;
    !relay_on [*2] |-> !relay_pwm;
  endproperty
  a_pwm_off: assert property (p_pwm_off) else $error("coil pwm late off");
  property p_ang_rng;
    angle_out_mv >= 14'h1388 && (angle_out_mv <= 14'h2328 || angle_out_mv == 14'h2710);
  endproperty
  a_ang_rng: assert property (p_ang_rng) else $error("angle out of range");
  property p_ang_zero;
    wheel_angle_deg == 7'h00 && !comm_lost_in |=> angle_out_mv == 14'h1388;
  endproperty
  a_ang_zero: assert property (p_ang_zero) else $error("angle zero not 5 V");
  property p_flt_back;
    !fault_action |=> fault_to_ilk || fault_to_coil;
  endproperty
  a_flt_back: assert property (p_flt_back) else $error("fault out not restored");
  c_code: cover property (fault_code == 6'h3f);
  c_relay: cover property ($rose(relay_on));
  c_flt: cover property ($fell(fault_to_ilk));
endmodule
bind ilrs_top ilrs_properties u_props (.*);
`default_nettype wire

// ### tb.sv
// self-checking bench of the sequencer
`timescale 1ns/10ps
`default_nettype none
module tb;
  import ilrs_pkg::*;
  logic ref_clk = 1'b0, rst_b = 1'b0, key = 1'b0, ilk = 1'b0, fa = 1'b0;
  logic pa = 1'b0, cl = 1'b0, wr = 1'b0, rd = 1'b0, relay_pwm, relay_on, f_ilk, f_coil, irq;
  logic [6:0] ang = 7'h00;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, n;
  logic [12:0] cmd = 13'h0, spd;
  logic [5:0] code;
  logic [13:0] mv;
  int n_errors = 0, compares = 0, seed = 62;
  always #25 ref_clk = ~ref_clk;
  ilrs_trac_model u_trac (.ref_clk(ref_clk), .speed_cmd(cmd), .angle_out_mv(mv), .trac_speed_rpm(spd));
  ilrs_top #(.TICK_CYCLES(20)) u_dut (.ref_clk(ref_clk), .rst_b(rst_b), .key_switch_input(key),
    .ilk_switch(ilk), .trac_speed_rpm(spd), .fault_action(fa), .prog_attached(pa), .comm_lost_in(cl),
    .wheel_angle_deg(ang), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .relay_pwm(relay_pwm), .relay_on(relay_on), .fault_to_ilk(f_ilk), .fault_to_coil(f_coil),
    .fault_code(code), .angle_out_mv(mv), .irq(irq));
  //======================================================================
  // tasks
  function automatic logic [31:0] exp_mv(input logic [6:0] a);
    return 32'(ANGLE_BASE_MV) + (32'(a) * 32'd11378) / 32'd256;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1;
    chk(rdata & m, e);
  endtask
  task automatic end_of_test;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  //======================================================================
  // scenarios
  initial
  begin
    #250000;
    n_errors++;
    end_of_test();
  end
  initial
  begin
    cyc(10);
    rst_b <= 1'b1;
    rd_chk(OFS_CTRL, '1, 32'h8);
    rd_chk(OFS_PULL_PCT, '1, 32'h64);
    rd_chk(8'h30, '1, 32'h0);
    pa <= 1'b1;
    cl <= 1'b1;
    cyc(3);
    chk(32'(code), 32'h3f);
    chk(32'(mv), 32'h2710);
    wr_reg(OFS_CTRL, 32'h0);
    repeat (4)
    begin
      ang <= 7'({$random(seed)} % 91);
      cyc(3);
      chk(32'(mv), exp_mv(ang));
    end
    pa <= 1'b0;
    cyc(2);
    chk(32'(code), 32'h0);
    wr_reg(OFS_HOLD_PCT, 32'h1e);
    wr_reg(OFS_OPEN_DLY, 32'h3);
    key <= 1'b1;
    cyc(5);
    chk(32'(relay_on), 32'h1);
    chk(32'(irq), 32'h0);
    rd_chk(OFS_IRQ_STAT, 32'h2, 32'h2);
    wr_reg(OFS_IRQ_EN, 32'h2);
    cyc(1);
    chk(32'(irq), 32'h1);
    wr_reg(OFS_IRQ_CLR, 32'h2);
    cyc(1);
    chk(32'(irq), 32'h0);
    rd_chk(OFS_STATUS, 32'h8, 32'h8);
    n = 0;
    repeat (100)
    begin
      cyc(1);
      n = n + 32'(relay_pwm);
    end
    chk(n, 32'h64);
    cyc(250);
    rd_chk(OFS_STATUS, 32'h8, 32'h0);
    n = 0;
    repeat (100)
    begin
      cyc(1);
      n = n + 32'(relay_pwm);
    end
    chk(n, 32'h1e);
    key <= 1'b0;
    cyc(40);
    chk(32'(relay_on), 32'h1);
    cyc(60);
    chk(32'(relay_on), 32'h0);
    wr_reg(OFS_CTRL, 32'h5);
    wr_reg(OFS_SEQ_DLY, 32'h2);
    ilk <= 1'b1;
    cyc(5);
    chk(32'(relay_on), 32'h1);
    ilk <= 1'b0;
    cyc(15);
    ilk <= 1'b1;
    cyc(30);
    rd_chk(OFS_STATUS, 32'h1, 32'h1);
    ilk <= 1'b0;
    cyc(100);
    rd_chk(OFS_STATUS, 32'h1, 32'h0);
    wr_reg(OFS_TRAC_MAX, 32'h3e8);
    wr_reg(OFS_ILK_PCT, 32'h32);
    cmd <= 13'h258;
    cyc(5);
    rd_chk(OFS_STATUS, 32'h3, 32'h3);
    cmd <= 13'h190;
    cyc(100);
    rd_chk(OFS_STATUS, 32'h1, 32'h0);
    wr_reg(OFS_CTRL, 32'h0);
    wr_reg(OFS_FLT_TMO, 32'h2);
    fa <= 1'b1;
    cyc(20);
    chk(32'(f_ilk), 32'h1);
    cyc(60);
    chk(32'(f_ilk), 32'h0);
    fa <= 1'b0;
    wr_reg(OFS_CTRL, 32'h2);
    cyc(2);
    chk({30'h0, f_coil, f_ilk}, 32'h2);
    end_of_test();
  end
endmodule
`default_nettype wire
